// File: inc/dsu_pkg.sv
// dsu_pkg: constants and carrier types for the dual-mode serial unit.
// assumes one system clock; all pins already synchronous to it.
package dsu_pkg;
  // baud accumulator: rate = (256 + mant) * 2^exp / 2^28 * f_clk
  localparam int BAUD_FRAC_W = 28;
  localparam logic [8:0] BAUD_M_BASE = 9'h100;
  localparam logic [5:0] OVS_SHIFT = 6'h04;  // 16 ticks per uart bit
  localparam logic [5:0] HALF_SHIFT = 6'h01; // 2 ticks per spi bit
  localparam logic [3:0] OVS_MID = 4'h7;
  localparam logic [3:0] OVS_LAST = 4'hF;
  localparam logic [3:0] UART_BITS_BASE = 4'hA; // start + 8 + stop
  localparam logic [3:0] RX_LAST_BASE = 4'h8;   // index of stop bit
  localparam logic [2:0] SPI_LAST_BIT = 3'h7;
  localparam logic [7:0] DATA_RESET = 8'h00;

  typedef struct packed {
    logic mode;               // 1 uart, 0 spi
    logic slave;              // spi slave when set
    logic receiver_enable;
    logic ninth_bit_enable;
    logic parity_en;
    logic parity_odd;
    logic ninth_data;         // ninth bit sent when not parity
    logic stop_bit_count_sel;
    logic stop_level;
    logic start_level;
    logic msb_first;
    logic cpol;
    logic flush;
    logic [7:0] baud_m;
    logic [4:0] baud_e;
  } dsu_cfg_type;

  typedef struct packed {
    logic dbuf_wr;            // write of data_buffer_reg
    logic dbuf_rd;            // read of data_buffer_reg
    logic csr_rd;             // read of ctrl_status_reg
    logic tx_done_clr;
    logic [7:0] wdata;
  } dsu_req_type;

  typedef struct packed {
    logic rxd;
    logic mosi;
    logic miso;
    logic sck;
    logic ssn_b;
  } dsu_pin_in_type;

  typedef struct packed {
    logic txd;
    logic mosi;
    logic mosi_oe_b;
    logic miso;
    logic miso_oe_b;
    logic sck;
    logic sck_oe_b;
  } dsu_pin_out_type;

  typedef struct packed {
    logic active;
    logic rx_byte;
    logic tx_byte;
    logic parity_err;
    logic framing_error_flag;
    logic rx_ninth_bit_enable;
    logic [7:0] data_buffer_reg;
  } dsu_stat_type;

  typedef struct packed {
    logic rx_irq;
    logic tx_irq;
    logic dma_rx;
    logic dma_tx;
  } dsu_evt_type;

  typedef enum logic {TX_IDLE = 1'b0, TX_SHIFT = 1'b1} dsu_tx_state_type;
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00, RX_HUNT = 2'b01, RX_SHIFT = 2'b10, RX_DONE = 2'b11
  } dsu_rx_state_type;
  typedef enum logic {SP_IDLE = 1'b0, SP_XFER = 1'b1} dsu_spi_state_type;
endpackage : dsu_pkg

// File: logic/dsu_top.sv
// dsu_top: two identical dual-mode serial units, uart or spi each.
// assumes core_clk_i at 25 MHz and every pin input synchronous to it.

module dsu_unit
  import dsu_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire dsu_cfg_type cfg_i,
  input wire dsu_req_type req_i,
  input wire dsu_pin_in_type pin_i,
  output dsu_pin_out_type pin_o,
  output dsu_stat_type stat_o,
  output dsu_evt_type evt_o
);

  function automatic logic [7:0] dsu_order(input logic [7:0] d,
                                           input logic rev);
    dsu_order = d;
    if (rev) dsu_order = {<<{d}};
  endfunction : dsu_order

  function automatic logic dsu_par(input logic [7:0] d,
                                   input logic odd);
    dsu_par = (^d) ^ odd;
  endfunction : dsu_par

  dsu_tx_state_type tx_st_q;
  dsu_rx_state_type rx_st_q;
  dsu_spi_state_type sp_st_q;
  logic [BAUD_FRAC_W-1:0] acc_q;
  logic [63:0] inc;
  logic [63:0] sum;
  logic [5:0] shamt;
  logic tick;
  logic uart;
  logic stop;
  logic [7:0] hold_q;
  logic hold_v_q;
  logic [11:0] tx_sh_q;
  logic [11:0] frame;
  logic [3:0] tx_left_q;
  logic [3:0] tx_ph_q;
  logic [3:0] tx_len;
  logic tx_load;
  logic tx_fin;
  logic [10:0] rx_sh_q;
  logic [3:0] rx_cnt_q;
  logic [3:0] rx_ph_q;
  logic [3:0] rx_last;
  logic [7:0] rx_ord;
  logic rx_fin;
  logic perr;
  logic ferr;
  logic stop1;
  logic stop2;
  logic [7:0] sp_sh_q;
  logic sp_smp_q;
  logic [2:0] sp_bit_q;
  logic sck_q;
  logic sck_prev_q;
  logic sp_in;
  logic sp_lead;
  logic sp_trail;
  logic sp_start;
  logic sp_take;
  logic sp_abort;
  logic sp_fin;
  logic [7:0] sp_rx;
  logic [7:0] rdata_q;
  logic rb9_q;
  logic rx_byte_q;
  logic tx_byte_q;
  logic err_q;
  logic fe_q;
  dsu_evt_type evt_q;

  assign uart = cfg_i.mode;
  assign stop = cfg_i.stop_level;

  // fractional baud accumulator; uart runs it 16x, spi master 2x
  assign shamt = {1'b0, cfg_i.baud_e} + (uart ? OVS_SHIFT : HALF_SHIFT);
  assign inc = 64'(BAUD_M_BASE + {1'b0, cfg_i.baud_m}) << shamt;
  assign sum = {{(64 - BAUD_FRAC_W){1'b0}}, acc_q} + inc;
  // a carry above bit 27 is one tick; several carries still give one
  assign tick = |sum[63:BAUD_FRAC_W];

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      acc_q <= '0;
    end else if (cfg_i.flush) begin
      acc_q <= '0;
    end else begin
      acc_q <= sum[BAUD_FRAC_W-1:0];
    end
  end

  // holding register: first stage of the double-buffered transmit
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hold_q <= DATA_RESET;
      hold_v_q <= 1'b0;
    end else if (cfg_i.flush) begin
      hold_q <= DATA_RESET;
      hold_v_q <= 1'b0;
    end else if (req_i.dbuf_wr) begin
      hold_q <= req_i.wdata;
      hold_v_q <= 1'b1;
    end else if (tx_load || sp_take) begin
      hold_v_q <= 1'b0;
    end
  end

  // uart frame on the line, lsb of the shifter goes out first
  assign tx_load = uart && !cfg_i.flush && tx_st_q == TX_IDLE && hold_v_q;
  assign tx_len = UART_BITS_BASE + {3'b000, cfg_i.ninth_bit_enable}
                  + {3'b000, cfg_i.stop_bit_count_sel};
  always_comb begin
    frame = {stop, stop, stop, dsu_order(hold_q, cfg_i.msb_first),
             cfg_i.start_level};
    if (cfg_i.ninth_bit_enable) begin
      frame[9] = cfg_i.parity_en ? dsu_par(hold_q, cfg_i.parity_odd)
                                 : cfg_i.ninth_data;
    end
  end
  assign tx_fin = tx_st_q == TX_SHIFT && tick && tx_ph_q == OVS_LAST &&
                  tx_left_q == 4'h1;

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tx_st_q <= TX_IDLE;
      tx_sh_q <= '1;
      tx_left_q <= 4'h0;
      tx_ph_q <= 4'h0;
    end else if (cfg_i.flush || !uart) begin
      tx_st_q <= TX_IDLE;
      tx_sh_q <= {12{stop}};
    end else begin
      case (tx_st_q)
        TX_IDLE: begin
          tx_sh_q <= {12{stop}}; // idle line sits at stop level
          tx_ph_q <= 4'h0;
          if (hold_v_q) begin
            tx_sh_q <= frame;
            tx_left_q <= tx_len;
            tx_st_q <= TX_SHIFT;
          end
        end
        TX_SHIFT: begin
          if (tick) begin
            tx_ph_q <= tx_ph_q + 4'h1;
            if (tx_ph_q == OVS_LAST) begin
              tx_sh_q <= {stop, tx_sh_q[11:1]};
              tx_left_q <= tx_left_q - 4'h1;
              if (tx_left_q == 4'h1) begin
                tx_st_q <= TX_IDLE;
              end
            end
          end
        end
        default: tx_st_q <= TX_IDLE;
      endcase
    end
  end

  // receiver has its own phase counter so it never shifts the tx bit grid
  assign rx_last = RX_LAST_BASE + {3'b000, cfg_i.ninth_bit_enable}
                   + {3'b000, cfg_i.stop_bit_count_sel};
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rx_st_q <= RX_IDLE;
      rx_sh_q <= '0;
      rx_cnt_q <= 4'h0;
      rx_ph_q <= 4'h0;
    end else if (cfg_i.flush || !uart || !cfg_i.receiver_enable) begin
      rx_st_q <= RX_IDLE;
      rx_ph_q <= 4'h0;
    end else begin
      case (rx_st_q)
        RX_IDLE: begin
          rx_st_q <= RX_HUNT;
          rx_ph_q <= 4'h0;
          rx_cnt_q <= 4'h0;
        end
        RX_HUNT: begin
          if (tick) begin
            if (pin_i.rxd == cfg_i.start_level) begin
              rx_ph_q <= rx_ph_q + 4'h1;
              if (rx_ph_q == OVS_MID) begin
                rx_st_q <= RX_SHIFT; // start still valid mid-bit
                rx_ph_q <= 4'h0;
              end
            end else begin
              rx_ph_q <= 4'h0; // glitch, keep hunting
            end
          end
        end
        RX_SHIFT: begin
          if (tick) begin
            rx_ph_q <= rx_ph_q + 4'h1;
            if (rx_ph_q == OVS_LAST) begin
              rx_sh_q[rx_cnt_q] <= pin_i.rxd;
              rx_cnt_q <= rx_cnt_q + 4'h1;
              if (rx_cnt_q == rx_last) begin
                rx_st_q <= RX_DONE;
              end
            end
          end
        end
        RX_DONE: rx_st_q <= RX_IDLE;
        default: rx_st_q <= RX_IDLE;
      endcase
    end
  end

  // character checks done once the whole frame is in
  assign rx_fin = rx_st_q == RX_DONE;
  assign rx_ord = dsu_order(rx_sh_q[7:0], cfg_i.msb_first);
  assign stop1 = cfg_i.ninth_bit_enable ? rx_sh_q[9] : rx_sh_q[8];
  assign stop2 = cfg_i.ninth_bit_enable ? rx_sh_q[10] : rx_sh_q[9];
  assign perr = cfg_i.ninth_bit_enable && cfg_i.parity_en &&
                rx_sh_q[8] != dsu_par(rx_ord, cfg_i.parity_odd);
  assign ferr = stop1 != stop ||
                (cfg_i.stop_bit_count_sel && stop2 != stop);

  // spi: master paces sck from the baud tick, slave follows sck pin
  assign sp_in = cfg_i.slave ? pin_i.mosi : pin_i.miso;
  assign sp_lead = cfg_i.slave ? (pin_i.sck ^ cfg_i.cpol) && !sck_prev_q
                               : tick && sck_q == cfg_i.cpol;
  assign sp_trail = cfg_i.slave ? !(pin_i.sck ^ cfg_i.cpol) && sck_prev_q
                                : tick && sck_q != cfg_i.cpol;
  assign sp_start = !uart && !cfg_i.flush && sp_st_q == SP_IDLE &&
                    (cfg_i.slave ? !pin_i.ssn_b : hold_v_q);
  assign sp_take = sp_start && hold_v_q;
  // slave deselected mid-byte drops the transfer
  assign sp_abort = cfg_i.slave && pin_i.ssn_b;
  assign sp_fin = sp_st_q == SP_XFER && !sp_abort && sp_trail &&
                  sp_bit_q == SPI_LAST_BIT;
  assign sp_rx = dsu_order({sp_sh_q[6:0], sp_smp_q}, !cfg_i.msb_first);

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sck_prev_q <= 1'b0;
    end else begin
      sck_prev_q <= pin_i.sck ^ cfg_i.cpol;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sp_st_q <= SP_IDLE;
      sp_sh_q <= DATA_RESET;
      sp_smp_q <= 1'b0;
      sp_bit_q <= 3'h0;
      sck_q <= 1'b0;
    end else if (cfg_i.flush || uart) begin
      sp_st_q <= SP_IDLE;
      sck_q <= cfg_i.cpol;
    end else begin
      case (sp_st_q)
        SP_IDLE: begin
          sck_q <= cfg_i.cpol;
          sp_bit_q <= 3'h0;
          if (sp_start) begin
            sp_sh_q <= hold_v_q ? dsu_order(hold_q, !cfg_i.msb_first)
                                : DATA_RESET;
            sp_st_q <= SP_XFER;
          end
        end
        SP_XFER: begin
          if (!cfg_i.slave && tick) begin
            sck_q <= !sck_q;
          end
          if (sp_abort) begin
            sp_st_q <= SP_IDLE;
          end else begin
            if (sp_lead) begin
              sp_smp_q <= sp_in;
            end
            if (sp_trail) begin
              sp_sh_q <= {sp_sh_q[6:0], sp_smp_q};
              sp_bit_q <= sp_bit_q + 3'h1;
              if (sp_bit_q == SPI_LAST_BIT) begin
                sp_st_q <= SP_IDLE;
              end
            end
          end
        end
        default: sp_st_q <= SP_IDLE;
      endcase
    end
  end

  // received data and status; a flag set beats a same-cycle clear, flush beats a data load
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_q <= DATA_RESET;
      rb9_q <= 1'b0;
    end else if (cfg_i.flush) begin
      rdata_q <= DATA_RESET;
      rb9_q <= 1'b0;
    end else if (rx_fin) begin
      rdata_q <= rx_ord;
      rb9_q <= rx_sh_q[8];
    end else if (sp_fin) begin
      rdata_q <= sp_rx;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rx_byte_q <= 1'b0;
    end else if (rx_fin || sp_fin) begin
      rx_byte_q <= 1'b1;
    end else if (req_i.dbuf_rd) begin
      rx_byte_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tx_byte_q <= 1'b0;
    end else if (tx_fin || sp_fin) begin
      tx_byte_q <= 1'b1;
    end else if (req_i.tx_done_clr) begin
      tx_byte_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      err_q <= 1'b0;
      fe_q <= 1'b0;
    end else begin
      if (rx_fin && perr) begin
        err_q <= 1'b1;
      end else if (req_i.csr_rd) begin
        err_q <= 1'b0;
      end
      if (rx_fin && ferr) begin
        fe_q <= 1'b1;
      end else if (req_i.csr_rd) begin
        fe_q <= 1'b0;
      end
    end
  end

  // one-cycle event pulses, registered one edge after the cause
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      evt_q <= '0;
    end else begin
      evt_q.rx_irq <= rx_fin || sp_fin;
      evt_q.tx_irq <= tx_load || sp_take;
      evt_q.dma_rx <= rx_fin || sp_fin;
      evt_q.dma_tx <= tx_fin || sp_fin;
    end
  end

  assign evt_o = evt_q;
  assign stat_o.active = tx_st_q != TX_IDLE || rx_st_q == RX_HUNT ||
                         rx_st_q == RX_SHIFT || sp_st_q != SP_IDLE;
  assign stat_o.rx_byte = rx_byte_q;
  assign stat_o.tx_byte = tx_byte_q;
  assign stat_o.parity_err = err_q;
  assign stat_o.framing_error_flag = fe_q;
  assign stat_o.rx_ninth_bit_enable = rb9_q;
  assign stat_o.data_buffer_reg = rdata_q;

  // pin drive; enables are low while this unit drives the pin
  assign pin_o.txd = tx_sh_q[0];
  assign pin_o.mosi = sp_sh_q[7];
  assign pin_o.miso = sp_sh_q[7];
  assign pin_o.sck = sck_q;
  assign pin_o.mosi_oe_b = !(!uart && !cfg_i.slave);
  assign pin_o.sck_oe_b = !(!uart && !cfg_i.slave);
  assign pin_o.miso_oe_b = !(!uart && cfg_i.slave && !pin_i.ssn_b);
endmodule : dsu_unit

module dsu_top
  import dsu_pkg::*;
#(
  parameter int UNITS = 2
) (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire dsu_cfg_type [UNITS-1:0] cfg_i,
  input wire dsu_req_type [UNITS-1:0] req_i,
  input wire dsu_pin_in_type [UNITS-1:0] pin_i,
  output dsu_pin_out_type [UNITS-1:0] pin_o,
  output dsu_stat_type [UNITS-1:0] stat_o,
  output dsu_evt_type [UNITS-1:0] evt_o
);
  // each unit has its own pins and settings, only clock and reset are shared
  for (genvar u = 0; u < UNITS; u++) begin : g_unit
    dsu_unit u_unit (
      .core_clk_i(core_clk_i),
      .rst_b_i(rst_b_i),
      .cfg_i(cfg_i[u]),
      .req_i(req_i[u]),
      .pin_i(pin_i[u]),
      .pin_o(pin_o[u]),
      .stat_o(stat_o[u]),
      .evt_o(evt_o[u])
    );
  end
endmodule : dsu_top

// File: sim/dsu_assertions.sv
// dsu_assertions: port-level checks on unit 0 of the serial pair.
// assumes one clock domain; the bit-timing check only arms at 16-cycle bits.
module dsu_assertions
  import dsu_pkg::*;
#(
  parameter int UNITS = 2
) (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire dsu_cfg_type [UNITS-1:0] cfg_i,
  input wire dsu_req_type [UNITS-1:0] req_i,
  input wire dsu_pin_in_type [UNITS-1:0] pin_i,
  input wire dsu_pin_out_type [UNITS-1:0] pin_o,
  input wire dsu_stat_type [UNITS-1:0] stat_o,
  input wire dsu_evt_type [UNITS-1:0] evt_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);

  dsu_cfg_type u0_cfg;
  logic quiet_q;

  // only unit 0 is watched; the bench proves unit 1 by its own compares
  assign u0_cfg = cfg_i[0];

  // a write that finds both directions idle, at the fast test rate
  sequence tx_launch;
    req_i[0].dbuf_wr && u0_cfg.mode && !u0_cfg.flush &&
      !u0_cfg.receiver_enable && !stat_o[0].active &&
      u0_cfg.baud_e == 5'h10 && u0_cfg.baud_m == 8'h00;
  endsequence

  // start bit holds sixteen cycles
  sequence start_bit;
    (pin_o[0].txd == u0_cfg.start_level) [*8] ##1
      (pin_o[0].txd == u0_cfg.start_level) [*8];
  endsequence

  chk_tx_launch_irq: assert property (tx_launch |-> ##2
    (evt_o[0].tx_irq && stat_o[0].active))
    else $error("transmit launch without interrupt or active");
  chk_tx_start_bit: assert property (tx_launch |->
    ##2 start_bit ##1
    (pin_o[0].txd == (u0_cfg.msb_first ? $past(req_i[0].wdata[7], 18) :
      $past(req_i[0].wdata[0], 18))))
    else $error("start bit or first data bit wrong");
  chk_tx_irq_pulse: assert property (evt_o[0].tx_irq |=>
    !evt_o[0].tx_irq)
    else $error("transmit interrupt longer than one cycle");
  chk_tx_dma_end: assert property ($rose(stat_o[0].tx_byte) &&
    u0_cfg.mode |-> ##[0:1] evt_o[0].dma_tx)
    else $error("transmit done without dma trigger");
  chk_rx_dma_pair: assert property (evt_o[0].rx_irq |->
    ##[0:1] evt_o[0].dma_rx)
    else $error("receive interrupt without dma trigger");
  chk_rd_clears_rx: assert property (req_i[0].dbuf_rd &&
    u0_cfg.mode && !u0_cfg.receiver_enable &&
    !$past(u0_cfg.receiver_enable) |=> !stat_o[0].rx_byte)
    else $error("buffer read left receive done set");
  chk_csr_clears_err: assert property (req_i[0].csr_rd &&
    u0_cfg.mode && !u0_cfg.receiver_enable &&
    !$past(u0_cfg.receiver_enable) |=>
    !stat_o[0].parity_err && !stat_o[0].framing_error_flag)
    else $error("status read left an error flag set");
  chk_uart_no_drive: assert property (u0_cfg.mode |->
    pin_o[0].mosi_oe_b && pin_o[0].miso_oe_b && pin_o[0].sck_oe_b)
    else $error("spi pin driven in uart mode");
  chk_spi_master_pins: assert property (!u0_cfg.mode &&
    !u0_cfg.slave |-> !pin_o[0].mosi_oe_b && !pin_o[0].sck_oe_b)
    else $error("master does not drive data and clock");
  chk_spi_slave_pins: assert property (!u0_cfg.mode &&
    u0_cfg.slave |-> pin_o[0].miso_oe_b == pin_i[0].ssn_b &&
    pin_o[0].mosi_oe_b && pin_o[0].sck_oe_b)
    else $error("slave output enable not following select");

  // flush held a second cycle must have silenced the unit
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      quiet_q <= 1'b0;
    end else begin
      quiet_q <= u0_cfg.flush;
    end
  end
  chk_flush_stops: assert property (quiet_q && u0_cfg.flush |->
    !stat_o[0].active)
    else $error("unit still active under flush");
endmodule : dsu_assertions

bind dsu_top dsu_assertions #(.UNITS(UNITS)) i_dsu_assertions (
  .core_clk_i(core_clk_i),
  .rst_b_i(rst_b_i),
  .cfg_i(cfg_i),
  .req_i(req_i),
  .pin_i(pin_i),
  .pin_o(pin_o),
  .stat_o(stat_o),
  .evt_o(evt_o)
);

// File: sim/dsu_peer.sv
// dsu_peer: remote uart station on one unit's line pair.
// assumes 16-cycle bits; the bench times capture from the transmit interrupt.
module dsu_peer (
  input wire logic clk_i,
  input wire logic txd_i,
  output logic rxd_o
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BIT_CYC = 16;

  // line rests at the default stop level until a character is sent
  initial rxd_o = 1'b1;

  // line bits go out lsb first, whole bit times, then the line rests idle
  task automatic send(input logic [15:0] bits, input int n,
                      input logic idle);
    for (int i = 0; i < n; i++) begin
      rxd_o = bits[i];
      repeat (BIT_CYC) @(negedge clk_i);
    end
    rxd_o = idle;
  endtask : send

  // sample mid-bit; lead puts the first sample half a bit into start
  task automatic grab(input int lead, input int n, output logic [15:0] bits);
    bits = 16'h0000;
    repeat (lead) @(negedge clk_i);
    for (int i = 0; i < n; i++) begin
      bits[i] = txd_i;
      repeat (BIT_CYC) @(negedge clk_i);
    end
  endtask : grab
endmodule : dsu_peer

// File: sim/tb.sv
// tb: self-checking bench for the dual serial pair, uart side in depth.
// assumes 16-cycle uart bits (mantissa 0, exponent 16) and a peer per unit.
module tb
  import dsu_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  localparam int WR = 11;
  localparam int RD = 10;
  localparam int CSR = 9;
  localparam int CLR = 8;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  dsu_cfg_type [1:0] cfg;
  dsu_req_type [1:0] req;
  dsu_pin_in_type [1:0] pin_in;
  dsu_pin_out_type [1:0] pin_out;
  dsu_stat_type [1:0] stat;
  dsu_evt_type [1:0] evt;
  logic [1:0] rxd;
  logic [1:0] ssn_b = 2'h3;
  int miscompares = 0;
  int check_count = 0;

  always #20 core_clk = ~core_clk;
  // unit 0 loops its mosi back into miso; other spi data and clock inputs rest low, selects rest high
  assign pin_in[0] = {rxd[0], 1'b0, pin_out[0].mosi, 1'b0, ssn_b[0]};
  assign pin_in[1] = {rxd[1], 3'h0, ssn_b[1]};

  dsu_top #(.UNITS(2)) i_dut (.core_clk_i(core_clk), .rst_b_i(rst_b),
    .cfg_i(cfg), .req_i(req), .pin_i(pin_in), .pin_o(pin_out),
    .stat_o(stat), .evt_o(evt));
  dsu_peer i_peer0 (.clk_i(core_clk), .txd_i(pin_out[0].txd),
    .rxd_o(rxd[0]));
  dsu_peer i_peer1 (.clk_i(core_clk), .txd_i(pin_out[1].txd),
    .rxd_o(rxd[1]));

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask : cyc

  task automatic chk(input string what, input logic [15:0] got,
                     input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // one-cycle request strobe, b is the bit within the request struct
  task automatic strobe(input int u, input int b);
    req[u][b] = 1'b1;
    cyc(1);
    req[u][b] = 1'b0;
  endtask : strobe

  // events stand one cycle, so look at every cycle up to the limit
  task automatic wait_evt(input int u, input int b, input int lim,
                          output logic seen);
    seen = 1'b0;
    for (int k = 0; k < lim && !seen; k++) begin
      cyc(1);
      seen = (evt[u][b] === 1'b1);
    end
  endtask : wait_evt

  function automatic dsu_cfg_type ucfg();
    dsu_cfg_type c;
    c = '0;
    c.mode = 1'b1;
    c.stop_level = 1'b1;
    c.baud_e = 5'h10;
    return c;
  endfunction : ucfg

  function automatic int flen(input dsu_cfg_type c);
    return 10 + int'(c.ninth_bit_enable) + int'(c.stop_bit_count_sel);
  endfunction : flen

  // line image lsb first; the tail at stop level covers stops and idle
  function automatic logic [15:0] frame(input dsu_cfg_type c,
                                        input logic [7:0] d);
    logic [15:0] f;
    f = {16{c.stop_level}};
    f[0] = c.start_level;
    for (int i = 0; i < 8; i++) f[1+i] = c.msb_first ? d[7-i] : d[i];
    if (c.ninth_bit_enable) f[9] = c.parity_en ? ^d ^ c.parity_odd :
      c.ninth_data;
    return f;
  endfunction : frame

  // second byte parked during shifting must start right after the stops
  task automatic tx_pair(input int u, input dsu_cfg_type c,
                         input logic [7:0] d1, input logic [7:0] d2);
    logic seen;
    logic [15:0] got;
    logic [15:0] e;
    int n;
    n = flen(c);
    e = (frame(c, d1) & ((16'h1 << n) - 16'h1)) | (frame(c, d2) << n);
    e = e & ((16'h1 << (n + 2)) - 16'h1);
    cfg[u] = c;
    cyc(2);
    req[u].wdata = d1;
    strobe(u, WR);
    wait_evt(u, 2, 8, seen);
    chk("tx start", 16'({seen, stat[u].active}), 16'h3);
    req[u].wdata = d2;
    strobe(u, WR);
    if (u == 0) i_peer0.grab(7, n + 2, got);
    else i_peer1.grab(7, n + 2, got);
    chk("tx line", got, e);
    for (int k = 0; k < 300 && stat[u].active !== 1'b0; k++) cyc(1);
    chk("tx done", 16'({stat[u].active, stat[u].tx_byte}), 16'h1);
    strobe(u, CLR);
  endtask : tx_pair

  // peer sends one character; flip marks the line bits it corrupts
  task automatic rx_case(input dsu_cfg_type c, input logic [7:0] d,
                         input logic [15:0] flip, input logic [1:0] err);
    logic seen;
    cfg[0] = c;
    cyc(2);
    chk("rx hunting", 16'(stat[0].active), 16'h1);
    fork
      i_peer0.send(frame(c, d) ^ flip, flen(c), c.stop_level);
      wait_evt(0, 3, 400, seen);
    join
    cyc(3);
    chk("rx done", 16'({seen, stat[0].rx_byte}), 16'h3);
    chk("rx data", 16'({stat[0].rx_ninth_bit_enable & c.ninth_bit_enable,
      stat[0].data_buffer_reg}), 16'({c.ninth_bit_enable & (flip[9] ^
      (c.parity_en ? ^d ^ c.parity_odd : c.ninth_data)), d}));
    chk("rx errors", 16'({stat[0].parity_err,
      stat[0].framing_error_flag}), 16'(err));
    cfg[0].receiver_enable = 1'b0;
    cyc(2);
    strobe(0, RD);
    strobe(0, CSR);
    cyc(1);
    chk("flags read off", 16'({stat[0].rx_byte,
      stat[0].parity_err, stat[0].framing_error_flag}), 16'h0);
  endtask : rx_case

  task automatic test_pin_roles();
    logic [2:0] e [4] = '{3'h7, 3'h2, 3'h5, 3'h7};
    for (int i = 0; i < 4; i++) begin
      cfg[0] = ucfg();
      cfg[0].mode = (i == 0);
      cfg[0].slave = (i >= 2);
      ssn_b[0] = (i != 2);
      cyc(1);
      chk("pin roles", 16'({pin_out[0].mosi_oe_b,
        pin_out[0].miso_oe_b, pin_out[0].sck_oe_b}), 16'(e[i]));
    end
    cfg[0] = ucfg();
    ssn_b[0] = 1'b1;
    cyc(4);
    $display("test pin_roles done");
  endtask : test_pin_roles

  task automatic test_tx_units();
    tx_pair(0, ucfg(), 8'hA5, 8'h3C);
    tx_pair(1, ucfg(), 8'h5A, 8'hC3);
    $display("test tx_units done");
  endtask : test_tx_units

  task automatic test_tx_formats();
    dsu_cfg_type c;
    for (int i = 0; i < 3; i++) begin
      c = ucfg();
      c.ninth_bit_enable = 1'b1;
      c.parity_en = (i != 2);
      c.parity_odd = (i == 1);
      c.ninth_data = 1'b1;
      c.msb_first = (i == 0);
      c.stop_bit_count_sel = (i == 0);
      c.start_level = (i == 1);
      c.stop_level = (i != 1);
      tx_pair(0, c, 8'h6B, 8'h81);
    end
    $display("test tx_formats done");
  endtask : test_tx_formats

  // receive and transmit overlap on one unit
  task automatic test_rx_duplex();
    dsu_cfg_type c;
    c = ucfg();
    c.receiver_enable = 1'b1;
    c.ninth_bit_enable = 1'b1;
    c.parity_en = 1'b1;
    fork
      rx_case(c, 8'hC6, 16'h0000, 2'h0);
      begin
        cyc(20);
        tx_pair(0, c, 8'h27, 8'hE4);
      end
    join
    $display("test rx_duplex done");
  endtask : test_rx_duplex

  task automatic test_rx_errors();
    dsu_cfg_type c;
    c = ucfg();
    c.receiver_enable = 1'b1;
    c.ninth_bit_enable = 1'b1;
    c.parity_en = 1'b1;
    c.parity_odd = 1'b1;
    c.stop_bit_count_sel = 1'b1;
    rx_case(c, 8'h5A, 16'h0200, 2'h2);
    rx_case(c, 8'h5A, 16'h0800, 2'h1);
    c.ninth_bit_enable = 1'b0;
    c.stop_bit_count_sel = 1'b0;
    rx_case(c, 8'h96, 16'h0200, 2'h1);
    c.msb_first = 1'b1;
    rx_case(c, 8'h3D, 16'h0000, 2'h0);
    $display("test rx_errors done");
  endtask : test_rx_errors

  // flush mid-character with a byte parked; nothing may resume after
  task automatic test_flush();
    logic seen;
    cfg[0] = ucfg();
    cyc(2);
    req[0].wdata = 8'hF0;
    strobe(0, WR);
    wait_evt(0, 2, 8, seen);
    req[0].wdata = 8'h0F;
    strobe(0, WR);
    cyc(40);
    cfg[0].flush = 1'b1;
    cyc(3);
    chk("flush stop", 16'({stat[0].active, pin_out[0].txd}), 16'h1);
    cfg[0].flush = 1'b0;
    cyc(400);
    chk("flush empty", 16'({stat[0].active, stat[0].tx_byte}), 16'h0);
    $display("test flush done");
  endtask : test_flush

  // spi master at full rate; the looped byte must come back intact
  task automatic test_spi_master();
    cfg[0] = ucfg();
    cfg[0].mode = 1'b0;
    cfg[0].cpol = 1'b1;
    cfg[0].baud_e = 5'h13;
    cyc(2);
    req[0].wdata = 8'h9C;
    strobe(0, WR);
    cyc(40);
    chk("spi loop", 16'({stat[0].rx_byte, stat[0].tx_byte,
      pin_out[0].sck, stat[0].data_buffer_reg}), 16'h79C);
    strobe(0, RD);
    strobe(0, CLR);
    cfg[0] = ucfg();
    cyc(2);
    $display("test spi_master done");
  endtask : test_spi_master

  task automatic report_and_stop();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop

  // main sequence; reset held five cycles, inputs move on falling edges
  initial begin
    cfg[0] = ucfg();
    cfg[1] = ucfg();
    req = '0;
    cyc(5);
    rst_b = 1'b1;
    cyc(2);
    test_pin_roles();
    test_tx_units();
    test_tx_formats();
    test_rx_duplex();
    test_rx_errors();
    test_flush();
    test_spi_master();
    report_and_stop();
  end

  // the run needs about 3400 cycles; nearly nine times that is a hang
  initial begin
    repeat (30000) @(posedge core_clk);
    miscompares++;
    $display("Error at %0t: watchdog expired", $time);
    report_and_stop();
  end
endmodule : tb
